// File: logic/fifo_pkg.sv
/*
 * Shared constants for the nine-bit first-in first-out buffer: pin
 * bit positions in the sampled input vector, reset values, the offset
 * register sequence and the default flag offsets.
 * Assumes a single system clock; both port clocks arrive as pins.
 */
package fifo_pkg;

   // ----------------------------------------------------------------
   // data path
   // ----------------------------------------------------------------
   localparam int DATA_W = 9;
   localparam int DEPTH_DEFAULT = 512;
   localparam int OFS_LO_W = 8;
   localparam int DEFAULT_OFFSET = 7;

   // ----------------------------------------------------------------
   // sampled pin vector layout
   // ----------------------------------------------------------------
   localparam int PIN_W = 17;
   localparam int PIN_WCLK = 16;
   localparam int PIN_RCLK = 15;
   localparam int PIN_RESET_N = 14;
   localparam int PIN_PRIMARY_WRITE_ENABLE_N_N = 13;
   localparam int PIN_SECOND_WRITE_ENABLE_OR_LOAD = 12;
   localparam int PIN_REN_A_N = 11;
   localparam int PIN_REN_B_N = 10;
   localparam int PIN_OE_N = 9;
   localparam int PIN_DATA_LSB = 0;
   // clocks low, reset asserted, dual input high, other enables and output enable inactive
   localparam logic [PIN_W-1:0] PIN_RESET_VAL = 17'h03E00;

   // ----------------------------------------------------------------
   // offset register sequence
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OFS_EMPTY_LO = 2'b00,
      OFS_EMPTY_HI = 2'b01,
      OFS_FULL_LO = 2'b10,
      OFS_FULL_HI = 2'b11
   } ofs_sel_t;

endpackage

// File: logic/pin_sync.sv
/*
 * Three-stage synchroniser for a vector of asynchronous pins.
 * Assumes the caller reads only the second and third stages.
 */
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // pins in
   input wire logic [W-1:0] pin_in,
   // stages out
   output logic [W-1:0] stage2,
   output logic [W-1:0] stage3
);

   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;
   logic [W-1:0] stage3_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1_reg <= RESET_VAL;
         stage2_reg <= RESET_VAL;
         stage3_reg <= RESET_VAL;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   assign stage2 = stage2_reg;
   assign stage3 = stage3_reg;

endmodule

// File: logic/sync_fifo_prog_flags.sv
/*
 * Nine-bit first-in first-out buffer with empty, full and programmable
 * almost-empty and almost-full flags, and a dual-purpose write enable
 * or offset load input chosen at reset.
 * Assumes clk is far faster than either port clock pin; every pin,
 * port clocks included, is sampled on clk and filtered.
 */
`timescale 1ns/100ps
module sync_fifo_prog_flags
   import fifo_pkg::*;
#(
   parameter int DEPTH = fifo_pkg::DEPTH_DEFAULT
) (
   // system clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // port clocks and device reset, as pins
   input wire logic write_side_clock,
   input wire logic read_side_clock,
   input wire logic reset_n,
   // write side
   input wire logic primary_write_enable_n,
   input wire logic second_write_enable_or_load,
   input wire logic [fifo_pkg::DATA_W-1:0] write_data_in,
   output logic full_flag_n,
   output logic almost_full_flag_n,
   // read side
   input wire logic read_enable_a_n,
   input wire logic read_enable_b_n,
   input wire logic output_enable_n,
   output logic [fifo_pkg::DATA_W-1:0] read_data_out,
   output logic read_data_oe_n,
   output logic empty_flag_n,
   output logic almost_empty_flag_n
);
   import fifo_pkg::*;

   localparam int ADDR_W = $clog2(DEPTH);
   localparam int CNT_W = ADDR_W + 1;
   localparam int OFS_HI_W = ADDR_W - OFS_LO_W;
   localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);
   localparam logic [ADDR_W-1:0] OFS_DEFAULT = ADDR_W'(DEFAULT_OFFSET);

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s2;
   logic [PIN_W-1:0] pins_s3;
   logic [PIN_W-1:0] pins_agree;
   logic [PIN_W-1:0] pins_lvl_reg;
   logic [PIN_W-1:0] pins_lvl_next;

   assign pins_raw = {write_side_clock, read_side_clock, reset_n,
                      primary_write_enable_n, second_write_enable_or_load,
                      read_enable_a_n, read_enable_b_n, output_enable_n,
                      write_data_in};

   pin_sync #(
      .W(PIN_W),
      .RESET_VAL(PIN_RESET_VAL)
   ) u_pin_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in(pins_raw),
      .stage2(pins_s2),
      .stage3(pins_s3)
   );

   // a pin level is taken only once the last two stages agree
   assign pins_agree = ~(pins_s2 ^ pins_s3);
   assign pins_lvl_next = (pins_s3 & pins_agree) |
                          (pins_lvl_reg & ~pins_agree);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pins_lvl_reg <= PIN_RESET_VAL;
      end else begin
         pins_lvl_reg <= pins_lvl_next;
      end
   end

   // ----------------------------------------------------------------
   // port clock edges and qualified controls
   // ----------------------------------------------------------------
   logic wclk_rise;
   logic rclk_rise;
   logic dev_rst;
   logic primary_write_enable_n_act;
   logic second_write_enable_or_load_lvl;
   logic ren_act;
   logic [DATA_W-1:0] din;

   // both port edges are events on clk, so neither port waits on the other
   assign wclk_rise = pins_lvl_next[PIN_WCLK] &
                      ~pins_lvl_reg[PIN_WCLK];
   assign rclk_rise = pins_lvl_next[PIN_RCLK] &
                      ~pins_lvl_reg[PIN_RCLK];
   assign dev_rst = sys_rst | ~pins_lvl_reg[PIN_RESET_N];
   // controls and data are the levels held just before the clock edge
   assign primary_write_enable_n_act = ~pins_lvl_reg[PIN_PRIMARY_WRITE_ENABLE_N_N];
   assign second_write_enable_or_load_lvl = pins_lvl_reg[PIN_SECOND_WRITE_ENABLE_OR_LOAD];
   assign ren_act = ~pins_lvl_reg[PIN_REN_A_N] & ~pins_lvl_reg[PIN_REN_B_N];
   assign din = pins_lvl_reg[PIN_DATA_LSB +: DATA_W];

   // ----------------------------------------------------------------
   // configuration strap
   // ----------------------------------------------------------------
   logic prog_mode_reg;

   // follows the inverted dual input throughout reset; the last value before
   // release is what stays
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         prog_mode_reg <= ~second_write_enable_or_load_lvl;
      end
   end

   logic load_low;
   assign load_low = prog_mode_reg & ~second_write_enable_or_load_lvl;

   // ----------------------------------------------------------------
   // operation decode
   // ----------------------------------------------------------------
   logic full_n_reg;
   logic almost_full_n_reg;
   logic empty_n_reg;
   logic almost_empty_n_reg;
   logic data_wr;
   logic data_rd;
   logic ofs_wr;
   logic ofs_rd;
   logic write_gate;

   // two-enable mode wants the dual input high; programmable mode
   // wants load high, so the same dual-input high gate qualifies data writes in both
   assign write_gate = second_write_enable_or_load_lvl;
   assign data_wr = wclk_rise & primary_write_enable_n_act & write_gate &
                    full_n_reg;
   assign data_rd = rclk_rise & ren_act & ~load_low & empty_n_reg;
   assign ofs_wr = wclk_rise & primary_write_enable_n_act & load_low;
   assign ofs_rd = rclk_rise & ren_act & load_low;

   // ----------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   logic [CNT_W-1:0] wptr_reg;
   logic [CNT_W-1:0] rptr_reg;
   logic [CNT_W-1:0] wptr_next;
   logic [CNT_W-1:0] rptr_next;

   // extra pointer bit tells full from empty when addresses match
   assign wptr_next = data_wr ? wptr_reg + CNT_W'(1) : wptr_reg;
   assign rptr_next = data_rd ? rptr_reg + CNT_W'(1) : rptr_reg;

   always_ff @(posedge clk) begin
      if (data_wr) begin
         mem[wptr_reg[ADDR_W-1:0]] <= din;
      end
   end

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         wptr_reg <= '0;
      end else begin
         wptr_reg <= wptr_next;
      end
   end

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         rptr_reg <= '0;
      end else begin
         rptr_reg <= rptr_next;
      end
   end

   // ----------------------------------------------------------------
   // offset registers
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] empty_ofs_reg;
   logic [ADDR_W-1:0] full_ofs_reg;
   ofs_sel_t wr_sel_reg;
   ofs_sel_t rd_sel_reg;

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         empty_ofs_reg <= OFS_DEFAULT;
         full_ofs_reg <= OFS_DEFAULT;
      end else if (ofs_wr) begin
         case (wr_sel_reg)
            OFS_EMPTY_LO: begin
               empty_ofs_reg[OFS_LO_W-1:0] <= din[OFS_LO_W-1:0];
            end
            OFS_EMPTY_HI: begin
               empty_ofs_reg[ADDR_W-1:OFS_LO_W] <= din[OFS_HI_W-1:0];
            end
            OFS_FULL_LO: begin
               full_ofs_reg[OFS_LO_W-1:0] <= din[OFS_LO_W-1:0];
            end
            default: begin
               full_ofs_reg[ADDR_W-1:OFS_LO_W] <= din[OFS_HI_W-1:0];
            end
         endcase
      end
   end

   // sequence positions survive leaving load mode, wrap after the fourth
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         wr_sel_reg <= OFS_EMPTY_LO;
      end else if (ofs_wr) begin
         wr_sel_reg <= ofs_sel_t'(wr_sel_reg + 2'b01);
      end
   end

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         rd_sel_reg <= OFS_EMPTY_LO;
      end else if (ofs_rd) begin
         rd_sel_reg <= ofs_sel_t'(rd_sel_reg + 2'b01);
      end
   end

   logic [DATA_W-1:0] ofs_view;

   always_comb begin
      case (rd_sel_reg)
         OFS_EMPTY_LO: ofs_view = DATA_W'(empty_ofs_reg[OFS_LO_W-1:0]);
         OFS_EMPTY_HI: ofs_view = DATA_W'(empty_ofs_reg[ADDR_W-1:OFS_LO_W]);
         OFS_FULL_LO: ofs_view = DATA_W'(full_ofs_reg[OFS_LO_W-1:0]);
         default: ofs_view = DATA_W'(full_ofs_reg[ADDR_W-1:OFS_LO_W]);
      endcase
   end

   // ----------------------------------------------------------------
   // output data register
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] dout_reg;

   // holds its word while either read enable is high
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         dout_reg <= '0;
      end else if (data_rd) begin
         dout_reg <= mem[rptr_reg[ADDR_W-1:0]];
      end else if (ofs_rd) begin
         dout_reg <= ofs_view;
      end
   end

   assign read_data_out = dout_reg;
   // low while driving; the pad resolves high impedance from this
   assign read_data_oe_n = pins_lvl_reg[PIN_OE_N];

   // ----------------------------------------------------------------
   // fill level and flags
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] fill_next;
   logic [CNT_W-1:0] full_thresh;

   // both pointers live on clk, so the difference never sees a pointer
   // mid-change and no gray crossing is needed
   assign fill_next = wptr_next - rptr_next;
   assign full_thresh = DEPTH_CNT - {1'b0, full_ofs_reg};

   // read-side flags move only on read clock edges and device reset
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         empty_n_reg <= 1'b0;
      end else if (rclk_rise) begin
         empty_n_reg <= (fill_next != '0);
      end
   end

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         almost_empty_n_reg <= 1'b0;
      end else if (rclk_rise) begin
         almost_empty_n_reg <=
            (fill_next > {1'b0, empty_ofs_reg});
      end
   end

   // write-side flags move only on write clock edges and device reset
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         full_n_reg <= 1'b1;
      end else if (wclk_rise) begin
         full_n_reg <= (fill_next != DEPTH_CNT);
      end
   end

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         almost_full_n_reg <= 1'b1;
      end else if (wclk_rise) begin
         almost_full_n_reg <= (fill_next < full_thresh);
      end
   end

   assign empty_flag_n = empty_n_reg;
   assign almost_empty_flag_n = almost_empty_n_reg;
   assign full_flag_n = full_n_reg;
   assign almost_full_flag_n = almost_full_n_reg;

endmodule

// File: tb/fifo_checker_asserts.sv
/* checker: flag, output and reset timing at the buffer pins.
   assumes port clock rises at least 8 clk apart. */
`timescale 1ns/100ps
module fifo_checker
   import fifo_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // pins in
   input wire logic write_side_clock,
   input wire logic read_side_clock,
   input wire logic reset_n,
   input wire logic output_enable_n,
   // pins out
   input wire logic [fifo_pkg::DATA_W-1:0] read_data_out,
   input wire logic read_data_oe_n,
   input wire logic full_flag_n,
   input wire logic almost_full_flag_n,
   input wire logic empty_flag_n,
   input wire logic almost_empty_flag_n
);
   logic [3:0] w_age, r_age, rst_age;
   logic wc_d, rc_d;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // ages since port clock rises and device reset; flags and output data may move only soon after
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      wc_d <= write_side_clock;
      rc_d <= read_side_clock;
      if (sys_rst || (write_side_clock && !wc_d)) w_age <= 4'h0;
      else if (w_age != 4'hF) w_age <= w_age + 4'h1;
      if (sys_rst || (read_side_clock && !rc_d)) r_age <= 4'h0;
      else if (r_age != 4'hF) r_age <= r_age + 4'h1;
      if (sys_rst || !reset_n) rst_age <= 4'h0;
      else if (rst_age != 4'hF) rst_age <= rst_age + 4'h1;
   end
   property p_ef_time;
      $changed(empty_flag_n) |-> r_age < 4'h8 || rst_age < 4'h8;
   endproperty
   property p_aef_time;
      $changed(almost_empty_flag_n) |-> r_age < 4'h8 || rst_age < 4'h8;
   endproperty
   property p_ff_time;
      $changed(full_flag_n) |-> w_age < 4'h8 || rst_age < 4'h8;
   endproperty
   property p_aff_time;
      $changed(almost_full_flag_n) |-> w_age < 4'h8 || rst_age < 4'h8;
   endproperty
   property p_q_time;
      $changed(read_data_out) |-> r_age < 4'h8 || rst_age < 4'h8;
   endproperty
   property p_reset;
      !reset_n [*8] |-> !empty_flag_n && !almost_empty_flag_n &&
         full_flag_n && almost_full_flag_n && read_data_out == 9'h000;
   endproperty
   property p_ef_aef;
      !empty_flag_n |-> !almost_empty_flag_n;
   endproperty
   property p_ff_aff;
      !full_flag_n |-> !almost_full_flag_n;
   endproperty
   property p_oe;
      $changed(output_enable_n) |-> ##[1:6]
         read_data_oe_n == output_enable_n;
   endproperty
   a_ef_time: assert property (p_ef_time)
      else $error("empty flag moved away from a read clock rise");
   a_aef_time: assert property (p_aef_time)
      else $error("almost empty flag moved away from a read clock rise");
   a_ff_time: assert property (p_ff_time)
      else $error("full flag moved away from a write clock rise");
   a_aff_time: assert property (p_aff_time)
      else $error("almost full flag moved away from a write clock rise");
   a_q_time: assert property (p_q_time)
      else $error("output data moved away from a read clock rise");
   a_reset: assert property (p_reset)
      else $error("wrong outputs during device reset");
   a_ef_aef: assert property (p_ef_aef)
      else $error("empty without almost empty");
   a_ff_aff: assert property (p_ff_aff)
      else $error("full without almost full");
   a_oe: assert property (p_oe)
      else $error("output drive did not follow output enable");
   c_full: cover property ($fell(full_flag_n));
   c_not_empty: cover property ($rose(empty_flag_n));
   c_almost_full: cover property ($fell(almost_full_flag_n));
endmodule
bind sync_fifo_prog_flags fifo_checker i_fifo_checker (.*);

// File: tb/fifo_port_agent.sv
/* pin agent for the writing and reading parties.
   assumes clk far faster than the port clocks it makes. */
`timescale 1ns/100ps
module fifo_port_agent
   import fifo_pkg::*;
(
   // system clock
   input wire logic clk,
   // pins toward the buffer
   output logic write_side_clock,
   output logic read_side_clock,
   output logic reset_n,
   output logic primary_write_enable_n,
   output logic second_write_enable_or_load,
   output logic [fifo_pkg::DATA_W-1:0] write_data_in,
   output logic read_enable_a_n,
   output logic read_enable_b_n
);
   initial begin
      {write_side_clock, read_side_clock, reset_n} = 3'h0;
      {primary_write_enable_n, read_enable_a_n, read_enable_b_n} = 3'h7;
      second_write_enable_or_load = 1'h1;
      write_data_in = 9'h000;
   end
   // ----------------------------------------------------------------
   // device reset; dual input level held across release
   // ----------------------------------------------------------------
   task automatic dev_reset(input logic dual);
      @(posedge clk);
      reset_n <= 1'h0;
      second_write_enable_or_load <= dual;
      repeat (10) @(posedge clk);
      reset_n <= 1'h1;
      repeat (8) @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // one port cycle: 4 clk setup, 6 clk high, then release
   // ----------------------------------------------------------------
   task automatic cycle(input logic w, input logic r,
      input logic [DATA_W-1:0] d, input logic wen_n, input logic dual,
      input logic ren_a, input logic ren_b);
      @(posedge clk);
      primary_write_enable_n <= wen_n;
      second_write_enable_or_load <= dual;
      write_data_in <= d;
      read_enable_a_n <= ren_a;
      read_enable_b_n <= ren_b;
      repeat (4) @(posedge clk);
      write_side_clock <= w;
      read_side_clock <= r;
      repeat (6) @(posedge clk);
      write_side_clock <= 1'h0;
      read_side_clock <= 1'h0;
      {primary_write_enable_n, read_enable_a_n, read_enable_b_n} <= 3'h7;
      write_data_in <= ~d; // released bus must not look held
   endtask
endmodule

// File: tb/tb_dual_clock_fifo_with_programmable_flags.sv
/* bench: queue model compared after every port clock rise.
   assumes fifo_port_agent drives the port pins. */
`timescale 1ns/100ps
module tb_dual_clock_fifo_with_programmable_flags;
   import fifo_pkg::*;
   localparam int DEPTH = 512;
   localparam int HI_MASK = (1 << ($clog2(DEPTH) - 8)) - 1;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic output_enable_n = 1'h0;
   logic write_side_clock, read_side_clock, reset_n, read_data_oe_n;
   logic primary_write_enable_n, second_write_enable_or_load;
   logic read_enable_a_n, read_enable_b_n, full_flag_n, empty_flag_n;
   logic almost_full_flag_n, almost_empty_flag_n;
   logic [DATA_W-1:0] write_data_in, read_data_out;
   int num_errors = 0;
   int checked = 0;
   int q[$];
   int ofs[4];
   int wsel, rsel, last, n_ofs, m_ofs;
   bit prog, ef, aef, ff, aff;
   always #2.5 clk = ~clk;
   fifo_port_agent i_fifo_port_agent (.*);
   sync_fifo_prog_flags #(.DEPTH(DEPTH)) i_sync_fifo_prog_flags (.*);
   task automatic chk(input string s, input logic [8:0] e, logic [8:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic flags();
      chk("empty_flag_n", ef, empty_flag_n);
      chk("almost_empty_flag_n", aef, almost_empty_flag_n);
      chk("full_flag_n", ff, full_flag_n);
      chk("almost_full_flag_n", aff, almost_full_flag_n);
      chk("read_data_out", last[8:0], read_data_out);
   endtask
   task automatic wr(input int d, input bit wen_n, input bit dual);
      i_fifo_port_agent.cycle(1'h1, 1'h0, d[8:0], wen_n, dual, 1'h1, 1'h1);
      #1;
      if (prog && !dual && !wen_n) begin
         ofs[wsel] = d & (wsel[0] ? HI_MASK : 32'hFF);
         wsel = (wsel + 1) % 4;
         n_ofs = ofs[0] + ofs[1] * 256;
         m_ofs = ofs[2] + ofs[3] * 256;
      end else if (!wen_n && dual && ff) q.push_back(d);
      ff = q.size() < DEPTH;
      aff = q.size() < DEPTH - m_ofs;
      flags();
   endtask
   task automatic wr_rd(input int d);
      i_fifo_port_agent.cycle(1'h1, 1'h1, d[8:0], 1'h0, 1'h1, 1'h0, 1'h0);
      #1;
      if (ff) q.push_back(d);
      if (ef) last = q.pop_front();
      ef = q.size() > 0;
      aef = q.size() > n_ofs;
      ff = q.size() < DEPTH;
      aff = q.size() < DEPTH - m_ofs;
      flags();
   endtask
   task automatic rd(input bit ra, input bit rb, input bit dual);
      i_fifo_port_agent.cycle(1'h0, 1'h1, 9'h000, 1'h1, dual, ra, rb);
      #1;
      if (prog && !dual) begin
         if (!ra && !rb) begin
            last = ofs[rsel];
            rsel = (rsel + 1) % 4;
         end
      end else if (!ra && !rb && ef) last = q.pop_front();
      ef = q.size() > 0;
      aef = q.size() > n_ofs;
      flags();
   endtask
   task automatic dev_reset(input bit dual);
      i_fifo_port_agent.dev_reset(dual);
      #1;
      q.delete();
      ofs = '{7, 0, 7, 0};
      {wsel, rsel, last, n_ofs, m_ofs} = {32'h0, 32'h0, 32'h0, 32'h7, 32'h7};
      prog = !dual;
      {ef, aef, ff, aff} = 4'h3;
      flags();
   endtask
   task automatic fill_drain();
      repeat (DEPTH + 2) wr($urandom % 512, 1'h0, 1'h1);
      repeat (DEPTH + 1) rd(1'h0, 1'h0, 1'h1);
   endtask
   task automatic end_sim();
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      end_sim();
   end
   initial begin
      void'($urandom(32'hd852));
      repeat (16) @(posedge clk);
      sys_rst <= 1'h0;
      dev_reset(1'h1);
      wr(9'h155, 1'h0, 1'h0);
      rd(1'h0, 1'h0, 1'h1);
      repeat (3) wr($urandom % 512, 1'h0, 1'h1);
      rd(1'h0, 1'h0, 1'h1);
      rd(1'h1, 1'h0, 1'h1);
      rd(1'h0, 1'h1, 1'h1);
      repeat (4) rd(1'h0, 1'h0, 1'h1);
      fill_drain();
      repeat (4) wr_rd($urandom % 512);
      @(posedge clk);
      output_enable_n <= 1'h1;
      repeat (8) @(posedge clk);
      chk("read_data_oe_n", 9'h001, read_data_oe_n);
      output_enable_n <= 1'h0;
      repeat (8) @(posedge clk);
      chk("read_data_oe_n", 9'h000, read_data_oe_n);
      dev_reset(1'h0);
      wr(9'h0AA, 1'h0, 1'h0);
      wr(9'h000, 1'h0, 1'h0);
      wr(9'h155, 1'h1, 1'h1);
      wr(9'h005, 1'h0, 1'h0);
      wr(9'h000, 1'h0, 1'h0);
      wr(9'h004, 1'h0, 1'h0);
      repeat (5) rd(1'h0, 1'h0, 1'h0);
      fill_drain();
      end_sim();
   end
endmodule
